/* rtl/cell_slave_end.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_slave_end
  import cell_link_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Link to the master
  cell_link_if.slave LINK,
  // Transmit queue fill
  input wire logic [WORD_W-1:0] TX_WORD,
  input wire logic TX_WORD_VALID,
  output logic TX_WORD_READY,
  // Receive queue drain
  output logic [WORD_W-1:0] RX_WORD,
  output logic RX_WORD_LAST,
  output logic RX_WORD_VALID,
  input wire logic RX_WORD_READY,
  // Service requests
  output logic TX_QUEUE_EVENT,
  output logic RX_QUEUE_EVENT,
  output logic ERROR_INTERRUPT
);
  typedef logic [1:0][15:0][WORD_W-1:0] queue_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [1:0] clk_d;
    logic [CFG_W-1:0] ctrl;
    queue_t txq;
    logic tx_wcell;
    logic [3:0] tx_wword;
    logic tx_rcell;
    logic [5:0] tx_idx;
    logic [1:0] tx_full;
    logic [1:0] tx_claim;
    logic tx_sel;
    logic tx_busy;
    logic tx_own;
    logic tx_soc;
    logic tx_clav;
    logic [BYTE_W-1:0] tx_byte;
    queue_t rxq;
    logic rx_wcell;
    logic [5:0] rx_idx;
    logic rx_busy;
    logic [1:0] rx_done;
    logic [1:0] rx_claim;
    logic rx_rcell;
    logic [3:0] rx_rword;
    logic rx_sel;
    logic rx_space;
    logic err;
  } slave_state_t;

  slave_state_t r_reg;
  slave_state_t r_next;

  logic [SYNC_W-1:0] pins;
  logic tx_edge, rx_edge, tx_match, rx_match, tx_ready;
  logic [6:0] tlen, rlen;
  logic [4:0] rwords, twords;
  logic [1:0] tpad, rpad;
  logic [ADDR_W-1:0] my_addr;
  logic [5:0] pos, rpos;
  logic tc_inc, tc_dec, tf_inc, tf_dec, rc_inc, rc_dec, rd_inc, rd_last;
  logic buf_in_ready;

  function automatic logic [BYTE_W-1:0] byte_at(input queue_t q, input logic c,
                                               input logic [5:0] p);
    return q[c][p[5:2]][{p[1:0], 3'b000} +: BYTE_W];
  endfunction : byte_at

  // Two edges of the link clocks are found only after the same two flops as their data
  assign pins = {LINK.tx_link_clock, LINK.rx_link_clock, LINK.tx_slave_select_bus,
                 LINK.tx_link_enable_n, LINK.rx_slave_select_bus, LINK.rx_link_enable_n,
                 LINK.rx_start_of_cell, LINK.rx_byte_bus};
  assign tx_edge = r_reg.s2[22] & ~r_reg.clk_d[1];
  assign rx_edge = r_reg.s2[21] & ~r_reg.clk_d[0];
  assign my_addr = r_reg.ctrl[CTL_SLID_LSB +: ADDR_W];
  assign tx_match = ~r_reg.ctrl[CTL_MULTI_PHY_ENABLE_BIT] || (r_reg.s2[20:16] == my_addr);
  assign rx_match = ~r_reg.ctrl[CTL_MULTI_PHY_ENABLE_BIT] || (r_reg.s2[14:10] == my_addr);
  assign tlen = cell_len(r_reg.ctrl[CTL_TXUDC_LSB +: 4]);
  assign rlen = cell_len(r_reg.ctrl[CTL_RXUDC_LSB +: 4]);
  assign twords = pkt_words(r_reg.ctrl[CTL_TXUDC_LSB +: 4]);
  assign rwords = pkt_words(r_reg.ctrl[CTL_RXUDC_LSB +: 4]);
  assign tpad = pad_bytes(r_reg.ctrl[CTL_TXUDC_LSB +: 4]);
  assign rpad = pad_bytes(r_reg.ctrl[CTL_RXUDC_LSB +: 4]);
  assign tx_ready = (r_reg.tx_wword != 4'h0) || (r_reg.tx_claim != QUEUE_CELLS);
  assign rd_last = ({1'b0, r_reg.rx_rword} == rwords - 5'h01);

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.clk_d = r_reg.s2[22:21];
    r_next.err = 1'b0;
    tc_inc = 1'b0;
    tc_dec = 1'b0;
    tf_inc = 1'b0;
    tf_dec = 1'b0;
    rc_inc = 1'b0;
    rc_dec = 1'b0;
    rd_inc = 1'b0;
    pos = {4'h0, tpad} + r_reg.tx_idx;
    rpos = {4'h0, rpad} + r_reg.rx_idx;
    if (LINK.cfg_write) begin
      r_next.ctrl = LINK.cfg_data;
    end
    // Word-wide fill; a slot is claimed by the first word of its packet
    if (TX_WORD_VALID && tx_ready) begin
      r_next.txq[r_reg.tx_wcell][r_reg.tx_wword] = TX_WORD;
      tc_inc = (r_reg.tx_wword == 4'h0);
      if ({1'b0, r_reg.tx_wword} == twords - 5'h01) begin
        r_next.tx_wword = 4'h0;
        r_next.tx_wcell = ~r_reg.tx_wcell;
        tf_inc = 1'b1;
      end else begin
        r_next.tx_wword = r_reg.tx_wword + 4'h1;
      end
    end
    if (tx_edge) begin
      r_next.tx_sel = tx_match;
      if (!r_reg.s2[15] && r_reg.tx_busy) begin
        r_next.tx_byte = byte_at(r_reg.txq, r_reg.tx_rcell, pos);
        r_next.tx_soc = 1'b0;
        if ({1'b0, r_reg.tx_idx} == tlen - 7'h01) begin
          r_next.tx_busy = 1'b0;
          r_next.tx_idx = 6'h00;
          r_next.tx_rcell = ~r_reg.tx_rcell;
          tf_dec = 1'b1;
          tc_dec = 1'b1;
        end else begin
          r_next.tx_idx = r_reg.tx_idx + 6'h01;
        end
      end else if (!r_reg.s2[15] && tx_match && r_reg.tx_full != 2'h0) begin
        // Pad bytes are skipped, so the first byte out is the first cell byte
        r_next.tx_byte = byte_at(r_reg.txq, r_reg.tx_rcell, {4'h0, tpad});
        r_next.tx_soc = 1'b1;
        r_next.tx_idx = 6'h01;
        r_next.tx_busy = 1'b1;
        r_next.tx_own = 1'b1;
      end else begin
        r_next.tx_soc = 1'b0;
        if (!r_reg.tx_busy) begin
          r_next.tx_own = 1'b0;
        end
      end
    end
    if (rx_edge) begin
      r_next.rx_sel = rx_match;
      if (!r_reg.s2[9] && rx_match) begin
        if (r_reg.s2[8] && (r_reg.rx_busy || r_reg.rx_claim != QUEUE_CELLS)) begin
          // A fresh start inside a cell abandons the short cell in place
          r_next.err = r_reg.rx_busy;
          rc_inc = ~r_reg.rx_busy;
          // The pad is under four bytes, so the first byte always lands in word 0
          r_next.rxq[r_reg.rx_wcell][4'h0][{rpad, 3'b000} +: BYTE_W] = r_reg.s2[7:0];
          r_next.rx_idx = 6'h01;
          r_next.rx_busy = 1'b1;
        end else if (r_reg.s2[8]) begin
          r_next.err = 1'b1;
        end else if (r_reg.rx_busy) begin
          r_next.rxq[r_reg.rx_wcell][rpos[5:2]][{rpos[1:0], 3'b000} +: BYTE_W] =
            r_reg.s2[7:0];
          if ({1'b0, r_reg.rx_idx} == rlen - 7'h01) begin
            r_next.rx_busy = 1'b0;
            r_next.rx_idx = 6'h00;
            r_next.rx_wcell = ~r_reg.rx_wcell;
            rd_inc = 1'b1;
          end else begin
            r_next.rx_idx = r_reg.rx_idx + 6'h01;
          end
        end
      end
    end
    // Drain side; a slot frees only when its last word leaves
    if (r_reg.rx_done != 2'h0 && buf_in_ready) begin
      if (rd_last) begin
        r_next.rx_rword = 4'h0;
        r_next.rx_rcell = ~r_reg.rx_rcell;
        rc_dec = 1'b1;
      end else begin
        r_next.rx_rword = r_reg.rx_rword + 4'h1;
      end
    end
    r_next.tx_claim = r_reg.tx_claim + {1'b0, tc_inc} - {1'b0, tc_dec};
    r_next.tx_full = r_reg.tx_full + {1'b0, tf_inc} - {1'b0, tf_dec};
    r_next.rx_claim = r_reg.rx_claim + {1'b0, rc_inc} - {1'b0, rc_dec};
    r_next.rx_done = r_reg.rx_done + {1'b0, rd_inc} - {1'b0, rc_dec};
    if (tx_edge) begin
      // A lone cell in flight does not count as the next one
      r_next.tx_clav = r_next.tx_busy ? (r_next.tx_full > 2'h1)
                                      : (r_next.tx_full != 2'h0);
    end
    if (rx_edge) begin
      // The cell in flight holds its slot, so a full queue drops this at its start
      r_next.rx_space = (r_next.rx_claim != QUEUE_CELLS);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      r_reg <= '0;
      r_reg.ctrl <= CTL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  pair_buffer #(
    .W(WORD_W + 1)
  ) u_rx_buf (
    .ref_clk(REF_CLK),
    .srst(SRST),
    .in_data({rd_last, r_reg.rxq[r_reg.rx_rcell][r_reg.rx_rword]}),
    .in_valid(r_reg.rx_done != 2'h0),
    .in_ready(buf_in_ready),
    .out_data({RX_WORD_LAST, RX_WORD}),
    .out_valid(RX_WORD_VALID),
    .out_ready(RX_WORD_READY)
  );

  assign TX_WORD_READY = tx_ready;
  assign TX_QUEUE_EVENT = (r_reg.tx_claim != QUEUE_CELLS);
  assign RX_QUEUE_EVENT = (r_reg.rx_done != 2'h0) && (r_reg.rx_rword == 4'h0);
  assign ERROR_INTERRUPT = r_reg.err;
  assign LINK.tx_cell_avail_o = r_reg.tx_clav;
  assign LINK.tx_cell_avail_oe = r_reg.tx_sel;
  assign LINK.tx_start_of_cell_o = r_reg.tx_soc;
  assign LINK.tx_byte_bus_o = r_reg.tx_byte;
  assign LINK.tx_data_oe = r_reg.tx_own;
  assign LINK.rx_space_avail_o = r_reg.rx_space;
  assign LINK.rx_space_avail_oe = r_reg.rx_sel;
endmodule : cell_slave_end
`default_nettype wire

/* rtl/cell_link_pkg.sv */
package cell_link_pkg;
  // Timing
  localparam int REF_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [2:0] HALF_LAST = 3'(LINK_HALF_CYC - 1);
  // Link and cell geometry
  localparam int ADDR_W = 5;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int CFG_W = 16;
  localparam int SYNC_W = 23;
  localparam logic [6:0] STD_CELL_BYTES = 7'h35;
  localparam logic [3:0] UDC_MAX = 4'hB;
  localparam logic [1:0] QUEUE_CELLS = 2'h2;
  // Control register layout and value after reset
  localparam int CTL_SLID_LSB = 0;
  localparam int CTL_MULTI_PHY_ENABLE_BIT = 5;
  localparam int CTL_TXUDC_LSB = 6;
  localparam int CTL_RXUDC_LSB = 10;
  localparam logic [15:0] CTL_RESET = 16'h0020;

  typedef enum logic [1:0] {T_POLL = 2'b00, T_READ = 2'b01, T_TAIL = 2'b11} read_state_t;
  typedef enum logic {S_POLL = 1'b0, S_SEND = 1'b1} send_state_t;

  function automatic logic [6:0] cell_len(input logic [3:0] udc);
    return STD_CELL_BYTES + {3'h0, (udc > UDC_MAX) ? UDC_MAX : udc};
  endfunction : cell_len

  function automatic logic [4:0] pkt_words(input logic [3:0] udc);
    logic [7:0] b;
    b = {1'b0, cell_len(udc)} + 8'h03;
    return b[6:2];
  endfunction : pkt_words

  function automatic logic [1:0] pad_bytes(input logic [3:0] udc);
    logic [6:0] t;
    t = {pkt_words(udc), 2'b00} - cell_len(udc);
    return t[1:0];
  endfunction : pad_bytes
endpackage : cell_link_pkg

/* rtl/cell_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cell_link_if;
  logic tx_link_clock;
  logic [cell_link_pkg::ADDR_W-1:0] tx_slave_select_bus;
  logic tx_link_enable_n;
  logic tx_cell_avail_o;
  logic tx_cell_avail_oe;
  logic tx_start_of_cell_o;
  logic [cell_link_pkg::BYTE_W-1:0] tx_byte_bus_o;
  logic tx_data_oe;
  logic rx_link_clock;
  logic [cell_link_pkg::ADDR_W-1:0] rx_slave_select_bus;
  logic rx_link_enable_n;
  logic rx_start_of_cell;
  logic [cell_link_pkg::BYTE_W-1:0] rx_byte_bus;
  logic rx_space_avail_o;
  logic rx_space_avail_oe;
  logic cfg_write;
  logic [cell_link_pkg::CFG_W-1:0] cfg_data;
  // Released lines read low, as with a weak pull-down
  logic tx_cell_avail;
  logic tx_start_of_cell;
  logic [cell_link_pkg::BYTE_W-1:0] tx_byte_bus;
  logic rx_space_avail;
  assign tx_cell_avail = tx_cell_avail_oe & tx_cell_avail_o;
  assign tx_start_of_cell = tx_data_oe & tx_start_of_cell_o;
  assign tx_byte_bus = tx_data_oe ? tx_byte_bus_o : '0;
  assign rx_space_avail = rx_space_avail_oe & rx_space_avail_o;

  modport slave (
    input tx_link_clock, tx_slave_select_bus, tx_link_enable_n,
    input rx_link_clock, rx_slave_select_bus, rx_link_enable_n, rx_start_of_cell, rx_byte_bus,
    input cfg_write, cfg_data,
    output tx_cell_avail_o, tx_cell_avail_oe, tx_start_of_cell_o, tx_byte_bus_o, tx_data_oe,
    output rx_space_avail_o, rx_space_avail_oe
  );
  modport master (
    output tx_link_clock, tx_slave_select_bus, tx_link_enable_n,
    output rx_link_clock, rx_slave_select_bus, rx_link_enable_n, rx_start_of_cell, rx_byte_bus,
    output cfg_write, cfg_data,
    input tx_cell_avail, tx_start_of_cell, tx_byte_bus, rx_space_avail
  );
endinterface : cell_link_if
`default_nettype wire

/* rtl/pair_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int W = 33
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } buf_state_t;

  buf_state_t r_reg;
  buf_state_t r_next;

  assign in_ready = (r_reg.cnt != 2'h2);
  assign out_valid = (r_reg.cnt != 2'h0);
  assign out_data = r_reg.mem[r_reg.rd];

  always_comb begin
    r_next = r_reg;
    if (in_valid && in_ready) begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = ~r_reg.wr;
    end
    if (out_valid && out_ready) begin
      r_next.rd = ~r_reg.rd;
    end
    r_next.cnt = r_reg.cnt + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : pair_buffer
`default_nettype wire

/* rtl/cell_master_end.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_master_end
  import cell_link_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Link to the slave
  cell_link_if.master LINK,
  // Setup
  input wire logic [ADDR_W-1:0] TARGET_ADDR,
  input wire logic [3:0] TX_UDC,
  input wire logic [3:0] RX_UDC,
  input wire logic CFG_WRITE,
  input wire logic [CFG_W-1:0] CFG_DATA,
  // Bytes read from the slave
  output logic [BYTE_W-1:0] CAPT_BYTE,
  output logic CAPT_FIRST,
  output logic CAPT_VALID,
  // Bytes sent to the slave
  input wire logic [BYTE_W-1:0] SEND_BYTE,
  input wire logic SEND_VALID,
  output logic SEND_READY
);
  typedef struct packed {
    logic [2:0] div;
    logic lclk;
    logic [10:0] s1;
    logic [10:0] s2;
    logic clav;
    logic space;
    read_state_t tstate;
    logic [6:0] tcnt;
    logic tx_enb_n;
    logic [BYTE_W-1:0] capt_byte;
    logic capt_first;
    logic capt_valid;
    send_state_t sstate;
    logic [6:0] scnt;
    logic rx_enb_n;
    logic rx_soc;
    logic [BYTE_W-1:0] rx_data;
    logic cfg_wr;
    logic [CFG_W-1:0] cfg_dat;
    logic [ADDR_W-1:0] addr;
  } master_state_t;

  master_state_t r_reg;
  master_state_t r_next;
  logic wrap, rise, fall, take;
  logic [6:0] tl, sl;

  assign wrap = (r_reg.div == HALF_LAST);
  assign rise = wrap & ~r_reg.lclk;
  assign fall = wrap & r_reg.lclk;
  assign tl = cell_len(TX_UDC);
  assign sl = cell_len(RX_UDC);
  assign SEND_READY = fall && ((r_reg.sstate == S_POLL) ? r_reg.space : (r_reg.scnt != sl));
  assign take = SEND_READY && SEND_VALID;

  always_comb begin
    r_next = r_reg;
    r_next.div = wrap ? 3'h0 : r_reg.div + 3'h1;
    r_next.lclk = r_reg.lclk ^ wrap;
    r_next.s1 = {LINK.tx_cell_avail, LINK.tx_start_of_cell, LINK.tx_byte_bus,
                 LINK.rx_space_avail};
    r_next.s2 = r_reg.s1;
    r_next.capt_valid = 1'b0;
    r_next.cfg_wr = CFG_WRITE;
    r_next.cfg_dat = CFG_DATA;
    r_next.addr = TARGET_ADDR;
    if (rise) begin
      r_next.clav = r_reg.s2[10];
      r_next.space = r_reg.s2[0];
      if (r_reg.tstate != T_POLL && (r_reg.tcnt != 7'h00 || r_reg.s2[9])) begin
        r_next.capt_byte = r_reg.s2[8:1];
        r_next.capt_first = (r_reg.tcnt == 7'h00);
        r_next.capt_valid = 1'b1;
        r_next.tcnt = r_reg.tcnt + 7'h01;
        if (r_reg.tcnt + 7'h01 == tl) begin
          r_next.tstate = T_POLL;
          r_next.tcnt = 7'h00;
        end
      end
    end
    if (fall) begin
      case (r_reg.tstate)
        T_POLL: begin
          if (r_reg.clav) begin
            r_next.tx_enb_n = 1'b0;
            r_next.tstate = T_READ;
          end
        end
        T_READ: begin
          // Released one cycle early so the slave does not start a second cell
          if (r_reg.tcnt >= tl - 7'h01) begin
            r_next.tx_enb_n = 1'b1;
            r_next.tstate = T_TAIL;
          end
        end
        default: begin
          r_next.tx_enb_n = 1'b1;
        end
      endcase
      case (r_reg.sstate)
        S_POLL: begin
          r_next.rx_enb_n = 1'b1;
          r_next.rx_soc = 1'b0;
          if (take) begin
            r_next.rx_data = SEND_BYTE;
            r_next.rx_soc = 1'b1;
            r_next.rx_enb_n = 1'b0;
            r_next.scnt = 7'h01;
            r_next.sstate = S_SEND;
          end
        end
        default: begin
          r_next.rx_soc = 1'b0;
          if (r_reg.scnt == sl) begin
            r_next.rx_enb_n = 1'b1;
            r_next.sstate = S_POLL;
          end else if (take) begin
            r_next.rx_data = SEND_BYTE;
            r_next.rx_enb_n = 1'b0;
            r_next.scnt = r_reg.scnt + 7'h01;
          end else begin
            // A byte gap pauses the cell with the enable high
            r_next.rx_enb_n = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      r_reg <= '0;
      r_reg.tx_enb_n <= 1'b1;
      r_reg.rx_enb_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign LINK.tx_link_clock = r_reg.lclk;
  assign LINK.rx_link_clock = r_reg.lclk;
  assign LINK.tx_slave_select_bus = r_reg.addr;
  assign LINK.rx_slave_select_bus = r_reg.addr;
  assign LINK.tx_link_enable_n = r_reg.tx_enb_n;
  assign LINK.rx_link_enable_n = r_reg.rx_enb_n;
  assign LINK.rx_start_of_cell = r_reg.rx_soc;
  assign LINK.rx_byte_bus = r_reg.rx_data;
  assign LINK.cfg_write = r_reg.cfg_wr;
  assign LINK.cfg_data = r_reg.cfg_dat;
  assign CAPT_BYTE = r_reg.capt_byte;
  assign CAPT_FIRST = r_reg.capt_first;
  assign CAPT_VALID = r_reg.capt_valid;
endmodule : cell_master_end
`default_nettype wire

/* test/cell_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_link_checker
  import cell_link_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Transmit link
  input wire logic tx_link_clock,
  input wire logic [ADDR_W-1:0] tx_slave_select_bus,
  input wire logic tx_link_enable_n,
  input wire logic tx_cell_avail_oe,
  input wire logic tx_start_of_cell,
  input wire logic [BYTE_W-1:0] tx_byte_bus,
  input wire logic tx_data_oe,
  // Receive link
  input wire logic rx_link_clock,
  input wire logic [ADDR_W-1:0] rx_slave_select_bus,
  input wire logic rx_space_avail,
  input wire logic rx_space_avail_oe,
  // Setup
  input wire logic cfg_write,
  input wire logic [CFG_W-1:0] cfg_data
);
  logic [4:0] own_reg;
  logic multi_phy_enable_reg, txc_reg, rxc_reg;
  logic [2:0] txa_reg, rxa_reg;
  logic [3:0] ena_reg;
  logic [6:0] len_reg;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // Shadow of the slave identity; ages count ref cycles since a link rise
  always_ff @(posedge REF_CLK) begin
    txc_reg <= tx_link_clock;
    rxc_reg <= rx_link_clock;
    if (SRST) begin
      own_reg <= 5'h00;
      multi_phy_enable_reg <= 1'b1;
      ena_reg <= 4'hF;
      len_reg <= 7'h7F;
      txa_reg <= 3'h7;
      rxa_reg <= 3'h7;
    end else begin
      if (cfg_write) begin
        own_reg <= cfg_data[CTL_SLID_LSB +: ADDR_W];
        multi_phy_enable_reg <= cfg_data[CTL_MULTI_PHY_ENABLE_BIT];
      end
      if (!tx_link_enable_n) ena_reg <= 4'h0;
      else if (ena_reg != 4'hF) ena_reg <= ena_reg + 4'h1;
      if ($rose(tx_start_of_cell)) len_reg <= 7'h00;
      else if (tx_link_clock && !txc_reg && len_reg != 7'h7F) len_reg <= len_reg + 7'h01;
      if (tx_link_clock && !txc_reg) txa_reg <= 3'h0;
      else if (txa_reg != 3'h7) txa_reg <= txa_reg + 3'h1;
      if (rx_link_clock && !rxc_reg) rxa_reg <= 3'h0;
      else if (rxa_reg != 3'h7) rxa_reg <= rxa_reg + 3'h1;
    end
  end

  sequence soc_byte;
    tx_start_of_cell [*8] ##1 !tx_start_of_cell;
  endsequence

  a_tx_clav_match: assert property (
    tx_cell_avail_oe |-> (!multi_phy_enable_reg || tx_slave_select_bus == own_reg))
    else $error("tx available driven while unselected");
  a_rx_clav_match: assert property (
    rx_space_avail_oe |-> (!multi_phy_enable_reg || rx_slave_select_bus == own_reg))
    else $error("rx space driven while unselected");
  a_soc_after_enable: assert property (
    $rose(tx_start_of_cell) |-> ena_reg < 4'h8)
    else $error("start of cell without enable");
  a_soc_one_byte: assert property (
    $rose(tx_start_of_cell) |-> soc_byte)
    else $error("start of cell not one link cycle");
  a_soc_with_data: assert property (
    $rose(tx_data_oe) |-> tx_start_of_cell)
    else $error("data driven without start of cell");
  a_cell_full_len: assert property (
    $rose(tx_start_of_cell) |-> len_reg >= STD_CELL_BYTES)
    else $error("cell cut short");
  a_tx_data_sync: assert property (
    $changed(tx_byte_bus) |-> txa_reg inside {[3'h1:3'h4]})
    else $error("tx data moved off the link edge");
  a_rx_space_sync: assert property (
    $changed(rx_space_avail) |-> rxa_reg inside {[3'h1:3'h4]})
    else $error("rx space moved off the link edge");
endmodule : cell_link_checker
`default_nettype wire

/* test/atm_cell_slave_port_8bit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module atm_cell_slave_port_8bit_test
  import cell_link_pkg::*;
;
  logic clk, srst, tx_valid, tx_ready, rx_last, rx_valid, rx_ready;
  logic tx_evt, rx_evt, err, cfg_write, capt_first, capt_valid, send_valid, send_ready;
  logic [31:0] tx_word, rx_word;
  logic [4:0] target;
  logic [3:0] tx_udc, rx_udc;
  logic [15:0] cfg_data;
  logic [7:0] capt_byte, send_byte;
  int n_fail, cmp_count, cap_cnt, err_cnt, ev_cnt;
  logic evt_q;

  cell_link_if lnk();
  cell_slave_end cell_slave_end_inst (.REF_CLK(clk), .SRST(srst), .LINK(lnk.slave),
    .TX_WORD(tx_word), .TX_WORD_VALID(tx_valid), .TX_WORD_READY(tx_ready),
    .RX_WORD(rx_word), .RX_WORD_LAST(rx_last), .RX_WORD_VALID(rx_valid),
    .RX_WORD_READY(rx_ready), .TX_QUEUE_EVENT(tx_evt), .RX_QUEUE_EVENT(rx_evt),
    .ERROR_INTERRUPT(err));
  cell_master_end cell_master_end_inst (.REF_CLK(clk), .SRST(srst), .LINK(lnk.master),
    .TARGET_ADDR(target), .TX_UDC(tx_udc), .RX_UDC(rx_udc), .CFG_WRITE(cfg_write),
    .CFG_DATA(cfg_data), .CAPT_BYTE(capt_byte), .CAPT_FIRST(capt_first),
    .CAPT_VALID(capt_valid), .SEND_BYTE(send_byte), .SEND_VALID(send_valid),
    .SEND_READY(send_ready));
  cell_link_checker cell_link_checker_inst (.REF_CLK(clk), .SRST(srst),
    .tx_link_clock(lnk.tx_link_clock), .tx_slave_select_bus(lnk.tx_slave_select_bus),
    .tx_link_enable_n(lnk.tx_link_enable_n), .tx_cell_avail_oe(lnk.tx_cell_avail_oe),
    .tx_start_of_cell(lnk.tx_start_of_cell), .tx_byte_bus(lnk.tx_byte_bus),
    .tx_data_oe(lnk.tx_data_oe), .rx_link_clock(lnk.rx_link_clock),
    .rx_slave_select_bus(lnk.rx_slave_select_bus), .rx_space_avail(lnk.rx_space_avail),
    .rx_space_avail_oe(lnk.rx_space_avail_oe), .cfg_write(lnk.cfg_write),
    .cfg_data(lnk.cfg_data));

  always #12.5 clk = ~clk;

  // Sampled away from the launching edge; the receive event is counted once per rise,
  // since the drain buffer may take the first word before the bench sees it
  always @(negedge clk) begin
    if (capt_valid === 1'b1) cap_cnt++;
    if (err === 1'b1) err_cnt++;
    if (rx_evt === 1'b1 && evt_q !== 1'b1) ev_cnt++;
    evt_q = rx_evt;
  end

  // Leading dummy bytes of a packet
  function automatic int padf(int u);
    return ((56 + u) / 4) * 4 - 53 - u;
  endfunction : padf

  function automatic logic [7:0] pb(int u, int c, int p);
    return (p < padf(u)) ? 8'hEE : 8'(c * 40 + p - padf(u));
  endfunction : pb

  function automatic logic sig(int s);
    case (s)
      0: return tx_ready;
      1: return capt_valid;
      2: return send_ready;
      default: return rx_valid;
    endcase
  endfunction : sig

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(string n, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : check

  // Handshakes are judged at the falling edge, where every output has settled
  task automatic await(int s);
    int t;
    t = 0;
    while (sig(s) !== 1'b1) begin
      @(negedge clk);
      t++;
      if (t > 4000) begin
        n_fail++;
        $display("Error wait %0d timed out", s);
        summarize();
      end
    end
  endtask : await

  task automatic cfg(logic [15:0] d);
    @(negedge clk);
    cfg_data <= d;
    cfg_write <= 1'b1;
    tx_udc <= d[9:6];
    rx_udc <= d[13:10];
    @(negedge clk);
    cfg_write <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : cfg

  task automatic push(int u, int c);
    for (int i = 0; i < (56 + u) / 4; i++) begin
      @(negedge clk);
      for (int j = 0; j < 4; j++) tx_word[j*8+:8] <= pb(u, c, i * 4 + j);
      tx_valid <= 1'b1;
      await(0);
    end
    @(negedge clk);
    tx_valid <= 1'b0;
  endtask : push

  task automatic pull(int u, int c);
    for (int k = 0; k < 53 + u; k++) begin
      await(1);
      check("capt_byte", capt_byte, pb(u, c, k + padf(u)));
      check("capt_first", capt_first, k == 0);
      @(negedge clk);
    end
  endtask : pull

  task automatic send(int u, int c);
    @(negedge clk);
    for (int k = 0; k < 53 + u; k++) begin
      send_byte <= pb(u, c, k + padf(u));
      send_valid <= 1'b1;
      await(2);
      @(negedge clk);
    end
    send_valid <= 1'b0;
  endtask : send

  task automatic drain(int u, int c);
    @(negedge clk);
    rx_ready <= 1'b1;
    for (int i = 0; i < (56 + u) / 4; i++) begin
      await(3);
      if (i == 0) begin
        check("rx_event", ev_cnt != 0, 1);
        ev_cnt--;
      end
      for (int j = 0; j < 4; j++)
        if (i * 4 + j >= padf(u)) check("rx_byte", rx_word[j*8+:8], pb(u, c, i * 4 + j));
      check("rx_last", rx_last, i == (56 + u) / 4 - 1);
      @(negedge clk);
    end
    rx_ready <= 1'b0;
  endtask : drain

  initial begin
    clk = 0; srst = 1; tx_word = '0; tx_valid = 0; rx_ready = 0; target = 5'h03;
    tx_udc = 0; rx_udc = 0; cfg_write = 0; cfg_data = '0; send_byte = '0; send_valid = 0;
    n_fail = 0; cmp_count = 0; cap_cnt = 0; err_cnt = 0; ev_cnt = 0; evt_q = 0;
    repeat (12) @(negedge clk);
    srst = 0;
    check("tx_event", tx_evt, 1);
    // Slave at address 9 while the master polls 3: the queue must fill untouched
    cfg(16'h0029);
    push(0, 1);
    push(0, 2);
    check("tx_ready", tx_ready, 0);
    check("tx_event", tx_evt, 0);
    repeat (800) @(negedge clk);
    check("captures", cap_cnt, 0);
    cfg(16'h0023);
    pull(0, 1);
    pull(0, 2);
    check("tx_event", tx_evt, 1);
    $display("transmit test done");
    send(0, 3);
    send(0, 4);
    drain(0, 3);
    drain(0, 4);
    $display("receive test done");
    cfg(16'h0009);
    push(0, 5);
    pull(0, 5);
    $display("single address test done");
    cfg(16'h2EE3);
    push(11, 6);
    pull(11, 6);
    send(11, 7);
    drain(11, 7);
    check("error_pulses", err_cnt, 0);
    check("rx_events_left", ev_cnt, 0);
    $display("user byte test done");
    summarize();
  end
endmodule : atm_cell_slave_port_8bit_test
`default_nettype wire
